// ===== dcf_pkg.sv
// Constants, register map and types for the time-signal receiver front end
package dcf_pkg;
  // Clock and time base
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          MS_NS         = 1000000;
  localparam int          MS_CYC        = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [16:0] MS_CNT_ONE    = 17'h0_0001;
  localparam logic [16:0] MS_CNT_ZERO   = 17'h0_0000;
  // Pulse windows in milliseconds
  localparam logic [11:0] BIT0_MIN_MS   = 12'h046;
  localparam logic [11:0] BIT0_MAX_MS   = 12'h082;
  localparam logic [11:0] BIT1_MIN_MS   = 12'h0AA;
  localparam logic [11:0] BIT1_MAX_MS   = 12'h0E6;
  localparam logic [11:0] PULSE_MIN_MS  = 12'h032;
  localparam logic [11:0] PULSE_MAX_MS  = 12'h0FA;
  localparam logic [11:0] PULL_IDLE_MS  = 12'h5DC;
  localparam logic [11:0] LEVEL_SAT_MS  = 12'hFFF;
  localparam logic [11:0] MS_ONE        = 12'h001;
  localparam logic [11:0] MS_ZERO       = 12'h000;
  localparam logic [5:0]  FRAME_BITS    = 6'h3B;
  localparam logic [5:0]  BITCNT_ONE    = 6'h01;
  // Register byte offsets
  localparam logic [4:0]  OFS_CTRL      = 5'h00;
  localparam logic [4:0]  OFS_HOUR      = 5'h04;
  localparam logic [4:0]  OFS_STATUS    = 5'h08;
  localparam logic [4:0]  OFS_BITS_LO   = 5'h0C;
  localparam logic [4:0]  OFS_BITS_HI   = 5'h10;
  // Control fields
  localparam int          CTRL_PULL_LSB = 0;
  localparam int          CTRL_POL_LSB  = 2;
  localparam int          CTRL_TOGGLE   = 4;
  localparam int          CTRL_SUP_HI   = 5;
  localparam int          CTRL_START    = 6;
  localparam int          CTRL_STOP     = 7;
  localparam logic [5:0]  CTRL_RST      = 6'h20;
  localparam logic [4:0]  HOUR_RST      = 5'h03;
  localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;
  // Pull-up and polarity modes
  localparam logic [1:0]  MODE_AUTO     = 2'h0;
  localparam logic [1:0]  MODE_ON       = 2'h1;
  localparam logic [1:0]  MODE_OFF      = 2'h2;
  // Decoder state
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } dcf_state_t;
endpackage

// ===== dcf_receiver_front_end.sv
// Time-signal receiver front end with pull-up, polarity, decode and supply control
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
module dcf_receiver_front_end #(
  parameter int MS_CYCLES = dcf_pkg::MS_CYC
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [4:0]  hour_now,
  input  wire logic        dcf_in,
  output logic             pullup_en,
  output logic             indicator_led,
  output logic             receiver_supply_control
);

  // Bus state
  logic                wait_reg;
  logic                wait_next;
  logic [31:0]         rdata_reg;
  logic [31:0]         rdata_next;
  logic [5:0]          ctrl_reg;
  logic [5:0]          ctrl_next;
  logic [4:0]          hour_reg;
  logic [4:0]          hour_next;
  logic                wr_go;
  logic                start_req;
  logic                stop_req;
  logic [4:0]          word_ofs;

  // Core state
  dcf_pkg::dcf_state_t state_reg;
  dcf_pkg::dcf_state_t state_next;
  logic                in_reg;
  logic                in_next;
  logic [16:0]         ms_cnt_reg;
  logic [16:0]         ms_cnt_next;
  logic [11:0]         level_ms_reg;
  logic [11:0]         level_ms_next;
  logic [11:0]         low_ms_reg;
  logic [11:0]         low_ms_next;
  logic [4:0]          hour_prev_reg;
  logic [4:0]          hour_prev_next;
  logic                pull_auto_reg;
  logic                pull_auto_next;
  logic                inv_auto_reg;
  logic                inv_auto_next;
  logic [58:0]         bits_reg;
  logic [58:0]         bits_next;
  logic [5:0]          bitcnt_reg;
  logic [5:0]          bitcnt_next;
  logic                lastbit_reg;
  logic                lastbit_next;
  logic                active_reg;
  logic                active_next;
  logic                pullup_reg;
  logic                pullup_next;
  logic                led_reg;
  logic                led_next;
  logic                supply_reg;
  logic                supply_next;

  // Decode helpers
  logic                run;
  logic                ms_tick;
  logic                in_edge;
  logic                inv_eff;
  logic                ended_active;
  logic                is_bit0;
  logic                is_bit1;
  logic                hour_hit;
  logic [1:0]          pull_mode;
  logic [1:0]          pol_mode;

  assign avs_readdata            = rdata_reg;
  assign avs_waitrequest         = wait_reg;
  assign pullup_en               = pullup_reg;
  assign indicator_led           = led_reg;
  assign receiver_supply_control = supply_reg;

  assign run       = (state_reg == dcf_pkg::ST_RUN);
  assign word_ofs  = {avs_address[4:2], 2'b00};
  assign wr_go     = avs_write && !wait_reg;
  assign start_req = wr_go && (word_ofs == dcf_pkg::OFS_CTRL)
                     && avs_writedata[dcf_pkg::CTRL_START];
  assign stop_req  = wr_go && (word_ofs == dcf_pkg::OFS_CTRL)
                     && avs_writedata[dcf_pkg::CTRL_STOP];
  assign pull_mode = ctrl_reg[dcf_pkg::CTRL_PULL_LSB +: 2];
  assign pol_mode  = ctrl_reg[dcf_pkg::CTRL_POL_LSB +: 2];
  assign ms_tick   = (ms_cnt_reg == 17'(MS_CYCLES - 1));
  assign in_edge   = dcf_in ^ in_reg;
  assign hour_hit  = (hour_now != hour_prev_reg) && (hour_now == hour_reg);

  // Polarity selection, auto or fixed, then optional toggle
  always_comb begin
    case (pol_mode)
      dcf_pkg::MODE_ON:  inv_eff = 1'b0;
      dcf_pkg::MODE_OFF: inv_eff = 1'b1;
      default:           inv_eff = inv_auto_reg;
    endcase
    inv_eff = inv_eff ^ ctrl_reg[dcf_pkg::CTRL_TOGGLE];
  end

  // Ended level was the active pulse of a second marker
  assign ended_active = run && in_edge && (in_reg ^ inv_eff);
  assign is_bit0 = ended_active && (level_ms_reg >= dcf_pkg::BIT0_MIN_MS)
                   && (level_ms_reg <= dcf_pkg::BIT0_MAX_MS);
  assign is_bit1 = ended_active && (level_ms_reg >= dcf_pkg::BIT1_MIN_MS)
                   && (level_ms_reg <= dcf_pkg::BIT1_MAX_MS);

  // Avalon slave: one wait cycle, then answer
  always_comb begin
    wait_next  = 1'b1;
    rdata_next = rdata_reg;
    ctrl_next  = ctrl_reg;
    hour_next  = hour_reg;
    if ((avs_read || avs_write) && wait_reg) begin
      wait_next = 1'b0;
    end
    if (avs_read && wait_reg) begin
      case (word_ofs)
        dcf_pkg::OFS_CTRL:    rdata_next = {26'h000_0000, ctrl_reg};
        dcf_pkg::OFS_HOUR:    rdata_next = {27'h000_0000, hour_reg};
        dcf_pkg::OFS_STATUS:  rdata_next = {21'h00_0000, bitcnt_reg, lastbit_reg,
                                            active_reg, inv_eff, pullup_reg, run};
        dcf_pkg::OFS_BITS_LO: rdata_next = bits_reg[31:0];
        dcf_pkg::OFS_BITS_HI: rdata_next = {5'h00, bits_reg[58:32]};
        default:              rdata_next = dcf_pkg::RDATA_ZERO;
      endcase
    end
    if (wr_go && (word_ofs == dcf_pkg::OFS_CTRL)) begin
      ctrl_next = avs_writedata[5:0];
    end
    if (wr_go && (word_ofs == dcf_pkg::OFS_HOUR)) begin
      hour_next = avs_writedata[4:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg  <= 1'b1;
      rdata_reg <= dcf_pkg::RDATA_ZERO;
      ctrl_reg  <= dcf_pkg::CTRL_RST;
      hour_reg  <= dcf_pkg::HOUR_RST;
    end else begin
      wait_reg  <= wait_next;
      rdata_reg <= rdata_next;
      ctrl_reg  <= ctrl_next;
      hour_reg  <= hour_next;
    end
  end

  // Pulse timing, detection, decode and receiver supply
  always_comb begin
    in_next        = dcf_in;
    hour_prev_next = hour_now;
    ms_cnt_next    = ms_tick ? dcf_pkg::MS_CNT_ZERO : ms_cnt_reg + dcf_pkg::MS_CNT_ONE;
    level_ms_next  = level_ms_reg;
    if (in_edge) begin
      level_ms_next = dcf_pkg::MS_ZERO;
    end else if (ms_tick && (level_ms_reg != dcf_pkg::LEVEL_SAT_MS)) begin
      level_ms_next = level_ms_reg + dcf_pkg::MS_ONE;
    end
    // Stuck-low time with pull-up off hints at an open-collector output
    low_ms_next = low_ms_reg;
    if (!run || in_reg || pullup_reg) begin
      low_ms_next = dcf_pkg::MS_ZERO;
    end else if (ms_tick && (low_ms_reg != dcf_pkg::LEVEL_SAT_MS)) begin
      low_ms_next = low_ms_reg + dcf_pkg::MS_ONE;
    end
    pull_auto_next = pull_auto_reg;
    if (run && (low_ms_reg >= dcf_pkg::PULL_IDLE_MS)) begin
      pull_auto_next = 1'b1;
    end
    case (pull_mode)
      dcf_pkg::MODE_ON:  pullup_next = 1'b1;
      dcf_pkg::MODE_OFF: pullup_next = 1'b0;
      default:           pullup_next = pull_auto_next;
    endcase
    // Short level marks the active sense of the input
    inv_auto_next = inv_auto_reg;
    if (run && in_edge && (level_ms_reg >= dcf_pkg::PULSE_MIN_MS)
        && (level_ms_reg <= dcf_pkg::PULSE_MAX_MS)) begin
      inv_auto_next = !in_reg;
    end
    bits_next    = bits_reg;
    bitcnt_next  = bitcnt_reg;
    lastbit_next = lastbit_reg;
    if (is_bit0 || is_bit1) begin
      bits_next    = {bits_reg[57:0], is_bit1};
      lastbit_next = is_bit1;
      bitcnt_next  = bitcnt_reg + dcf_pkg::BITCNT_ONE;
    end
    case (state_reg)
      dcf_pkg::ST_IDLE: begin
        state_next = dcf_pkg::ST_IDLE;
        if (start_req || hour_hit) begin
          state_next  = dcf_pkg::ST_RUN;
          bits_next   = 59'h0;
          bitcnt_next = 6'h00;
        end
      end
      dcf_pkg::ST_RUN: begin
        state_next = dcf_pkg::ST_RUN;
        if (stop_req || (bitcnt_reg == dcf_pkg::FRAME_BITS)) begin
          state_next = dcf_pkg::ST_IDLE;
        end
      end
      default: state_next = dcf_pkg::ST_IDLE;
    endcase
    active_next = dcf_in ^ inv_eff;
    led_next    = (state_next == dcf_pkg::ST_RUN) && active_next;
    supply_next = (state_next == dcf_pkg::ST_RUN)
                  ? ctrl_next[dcf_pkg::CTRL_SUP_HI]
                  : !ctrl_next[dcf_pkg::CTRL_SUP_HI];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= dcf_pkg::ST_IDLE;
      in_reg        <= 1'b0;
      hour_prev_reg <= 5'h00;
      ms_cnt_reg    <= dcf_pkg::MS_CNT_ZERO;
      level_ms_reg  <= dcf_pkg::MS_ZERO;
      low_ms_reg    <= dcf_pkg::MS_ZERO;
      pull_auto_reg <= 1'b0;
      inv_auto_reg  <= 1'b0;
      bits_reg      <= 59'h0;
      bitcnt_reg    <= 6'h00;
      lastbit_reg   <= 1'b0;
      active_reg    <= 1'b0;
      pullup_reg    <= 1'b0;
      led_reg       <= 1'b0;
      supply_reg    <= 1'b0;
    end else begin
      state_reg     <= state_next;
      in_reg        <= in_next;
      hour_prev_reg <= hour_prev_next;
      ms_cnt_reg    <= ms_cnt_next;
      level_ms_reg  <= level_ms_next;
      low_ms_reg    <= low_ms_next;
      pull_auto_reg <= pull_auto_next;
      inv_auto_reg  <= inv_auto_next;
      bits_reg      <= bits_next;
      bitcnt_reg    <= bitcnt_next;
      lastbit_reg   <= lastbit_next;
      active_reg    <= active_next;
      pullup_reg    <= pullup_next;
      led_reg       <= led_next;
      supply_reg    <= supply_next;
    end
  end

  // Checks
  property p_supply_level;
    @(posedge clock) disable iff (!rst_n)
      supply_reg == (run ? ctrl_reg[dcf_pkg::CTRL_SUP_HI] : !ctrl_reg[dcf_pkg::CTRL_SUP_HI]);
  endproperty
  a_supply_level: assert property (p_supply_level)
    else $error("supply output level does not match decode state");

  property p_led_active;
    @(posedge clock) disable iff (!rst_n)
      led_reg |-> (run && active_reg);
  endproperty
  a_led_active: assert property (p_led_active)
    else $error("indicator lit outside an active pulse");

  property p_pull_forced_on;
    @(posedge clock) disable iff (!rst_n)
      (pull_mode == dcf_pkg::MODE_ON) ##1 (pull_mode == dcf_pkg::MODE_ON) |-> pullup_reg;
  endproperty
  a_pull_forced_on: assert property (p_pull_forced_on)
    else $error("pull-up not on while forced on");

  property p_pull_forced_off;
    @(posedge clock) disable iff (!rst_n)
      (pull_mode == dcf_pkg::MODE_OFF) ##1 (pull_mode == dcf_pkg::MODE_OFF) |-> !pullup_reg;
  endproperty
  a_pull_forced_off: assert property (p_pull_forced_off)
    else $error("pull-up on while forced off");

  property p_toggle_flips;
    @(posedge clock) disable iff (!rst_n)
      (pol_mode == dcf_pkg::MODE_OFF) |-> (inv_eff == !ctrl_reg[dcf_pkg::CTRL_TOGGLE]);
  endproperty
  a_toggle_flips: assert property (p_toggle_flips)
    else $error("fixed inverted polarity not flipped by toggle");

  property p_bit0;
    @(posedge clock) disable iff (!rst_n)
      is_bit0 |=> (!lastbit_reg && !bits_reg[0]
                   && bitcnt_reg == 6'($past(bitcnt_reg) + dcf_pkg::BITCNT_ONE));
  endproperty
  a_bit0: assert property (p_bit0)
    else $error("short pulse not decoded as zero");

  property p_bit1;
    @(posedge clock) disable iff (!rst_n)
      is_bit1 |=> (lastbit_reg && bits_reg[0]);
  endproperty
  a_bit1: assert property (p_bit1)
    else $error("long pulse not decoded as one");

  property p_hour_start;
    @(posedge clock) disable iff (!rst_n)
      (!run && hour_hit) |=> (run && bitcnt_reg == 6'h00) ##1 supply_reg == ctrl_reg[5];
  endproperty
  a_hour_start: assert property (p_hour_start)
    else $error("decode did not start at the configured hour");

  property p_frame_stop;
    @(posedge clock) disable iff (!rst_n)
      (run && bitcnt_reg == dcf_pkg::FRAME_BITS) |=> !run;
  endproperty
  a_frame_stop: assert property (p_frame_stop)
    else $error("decode kept running after a full frame");

  property p_bus_answer;
    @(posedge clock) disable iff (!rst_n)
      ((avs_read || avs_write) && wait_reg) |=> !wait_reg ##1 wait_reg;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer not given after one wait cycle");

endmodule // dcf_receiver_front_end

// ===== dcf_rx_model.sv
// Behavioural model of the external time-signal receiver module
`timescale 1ns/1ns
module dcf_rx_model #(
  parameter int MS = 10
) (
  input  wire logic clock,
  input  wire logic supply,
  input  wire logic sup_hi,
  input  wire logic pullup_en,
  output logic      dcf_in
);
  logic inv  = 1'b0;
  logic act  = 1'b0;
  logic flip = 1'b0;
  logic od   = 1'b0;
  wire  powered = (supply === sup_hi);
  always_ff @(posedge clock) begin
    flip <= !flip;
  end
  // Driven while powered, floating otherwise
  // Open-collector output reads low without the pull-up
  assign dcf_in = powered ? ((od && !pullup_en) ? 1'b0 : (act ^ inv))
                          : (pullup_en ? 1'b1 : flip);
  // One second marker, then rest
  task automatic send_bit(input logic b);
    @(posedge clock);
    act <= 1'b1;
    repeat ((b ? 200 : 100) * MS) @(posedge clock);
    act <= 1'b0;
    repeat (300 * MS) @(posedge clock);
  endtask
endmodule // dcf_rx_model

// ===== tb_dcf_receiver_front_end.sv
// Self-checking bench for the time-signal receiver front end
`timescale 1ns/1ns
module tb_dcf_receiver_front_end;
  localparam int MS = 10;
  logic        clock;
  logic        rst_n;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [4:0]  hour_now;
  logic        dcf_in;
  logic        pullup_en;
  logic        indicator_led;
  logic        receiver_supply_control;
  logic        sup_hi;
  logic [31:0] q;
  logic [31:0] exp_lo;
  logic [31:0] r;
  logic [5:0]  cnt;
  logic [4:0]  h;
  logic        b;
  int          bad_count;
  int          n_compared;
  int          seed;
  dcf_receiver_front_end #(.MS_CYCLES(MS)) dut (
    .clock                   (clock),
    .rst_n                   (rst_n),
    .avs_address             (avs_address),
    .avs_read                (avs_read),
    .avs_write               (avs_write),
    .avs_writedata           (avs_writedata),
    .avs_readdata            (avs_readdata),
    .avs_waitrequest         (avs_waitrequest),
    .hour_now                (hour_now),
    .dcf_in                  (dcf_in),
    .pullup_en               (pullup_en),
    .indicator_led           (indicator_led),
    .receiver_supply_control (receiver_supply_control)
  );
  dcf_rx_model #(.MS(MS)) rx (
    .clock     (clock),
    .supply    (receiver_supply_control),
    .sup_hi    (sup_hi),
    .pullup_en (pullup_en),
    .dcf_in    (dcf_in)
  );
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One Avalon transfer, held until waitrequest low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic settle();
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask
  initial begin
    repeat (90000) @(posedge clock);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    seed = 93696;
    bad_count = 0;
    n_compared = 0;
    rst_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    hour_now = 5'h00;
    sup_hi = 1'b1;
    exp_lo = 32'h0000_0000;
    cnt = 6'h00;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    settle();
    check("supply", receiver_supply_control, 1'b0);
    bus(1'b0, dcf_pkg::OFS_CTRL, 32'h0000_0000);
    check("ctrl", q, 32'h0000_0020);
    bus(1'b0, dcf_pkg::OFS_HOUR, 32'h0000_0000);
    check("hour", q, 32'h0000_0003);
    bus(1'b0, 5'h14, 32'h0000_0000);
    check("unmapped", q, 32'h0000_0000);
    // Fixed normal polarity, pull-up forced on, start
    bus(1'b1, dcf_pkg::OFS_CTRL, 32'h0000_0065);
    settle();
    check("supply", receiver_supply_control, 1'b1);
    check("pullup", pullup_en, 1'b1);
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      b = r[0];
      fork
        rx.send_bit(b);
        begin
          repeat (50 * MS) @(posedge clock);
          @(negedge clock);
          check("led_on", indicator_led, 1'b1);
        end
      join
      exp_lo = {exp_lo[30:0], b};
      cnt = cnt + 6'h01;
      check("led_off", indicator_led, 1'b0);
    end
    bus(1'b0, dcf_pkg::OFS_BITS_LO, 32'h0000_0000);
    check("bits", q, exp_lo);
    bus(1'b0, dcf_pkg::OFS_BITS_HI, 32'h0000_0000);
    check("bits_hi", q, 32'h0000_0000);
    bus(1'b0, dcf_pkg::OFS_STATUS, 32'h0000_0000);
    check("status", q, {21'h0, cnt, b, 4'h3});
    // Stop with pull-up forced off
    bus(1'b1, dcf_pkg::OFS_CTRL, 32'h0000_00A6);
    settle();
    check("supply", receiver_supply_control, 1'b0);
    check("pullup", pullup_en, 1'b0);
    bus(1'b1, dcf_pkg::OFS_CTRL, 32'h0000_0005);
    sup_hi <= 1'b0;
    settle();
    check("supply", receiver_supply_control, 1'b1);
    // Daily start at the chosen hour
    r = $random(seed);
    h = 5'h04 + {1'b0, r[3:0]};
    bus(1'b1, dcf_pkg::OFS_HOUR, {27'h0, h});
    hour_now <= h;
    settle();
    check("supply", receiver_supply_control, 1'b0);
    bus(1'b0, dcf_pkg::OFS_STATUS, 32'h0000_0000);
    check("run", q[0], 1'b1);
    // Inversion toggle turns the idle low level active
    bus(1'b1, dcf_pkg::OFS_CTRL, 32'h0000_0015);
    settle();
    check("led_tog", indicator_led, 1'b1);
    bus(1'b0, dcf_pkg::OFS_STATUS, 32'h0000_0000);
    check("inv", q[2], 1'b1);
    // Automatic polarity with an inverting receiver
    bus(1'b1, dcf_pkg::OFS_CTRL, 32'h0000_00A1);
    rx.inv <= 1'b1;
    sup_hi <= 1'b1;
    bus(1'b1, dcf_pkg::OFS_CTRL, 32'h0000_0061);
    settle();
    rx.send_bit(1'b0);
    bus(1'b0, dcf_pkg::OFS_STATUS, 32'h0000_0000);
    check("auto_inv", q[2], 1'b1);
    check("led_idle", indicator_led, 1'b0);
    // Fixed inverted polarity, open-collector receiver, automatic pull-up
    rx.od <= 1'b1;
    bus(1'b1, dcf_pkg::OFS_CTRL, 32'h0000_0028);
    settle();
    check("led_inv", indicator_led, 1'b1);
    bus(1'b0, dcf_pkg::OFS_STATUS, 32'h0000_0000);
    check("fixed_inv", q[2], 1'b1);
    check("pull_low", q[1], 1'b0);
    repeat (1600 * MS) @(posedge clock);
    @(negedge clock);
    check("pull_auto", pullup_en, 1'b1);
    tally_and_finish();
  end
endmodule // tb_dcf_receiver_front_end
